// file: sss_core.sv
// safe stop sequencer core: torque_off, stop_one and brake_control sequencing
`timescale 1ns/1ps

module sss_core
  import sss_pkg::*;
#(
  parameter int unsigned SPD_W = 16  // width of signed speed value
)
(
  input  wire logic                       i_clk_sys,        // system clock
  input  wire logic                       i_reset_n,        // synchronous reset, low
  input  wire sss_cfg_s                   i_cfg,            // configuration
  input  wire logic [SSS_DELAY_MAX_W-1:0] i_delay_cycles,   // stop_one delay in cycles
  input  wire sss_sel_s                   i_sel_comm,       // channel selection
  input  wire sss_sel_s                   i_sel_term,       // terminal module selection
  input  wire sss_sel_s                   i_sel_pin,        // failsafe_input pins, async
  input  wire logic                       i_motor_on,       // drive pulses enabled
  input  wire logic signed [SPD_W-1:0]    i_speed,          // actual speed, signed
  input  wire logic [SPD_W-1:0]           i_spd_shutdown,   // shutdown threshold
  input  wire logic [SPD_W-1:0]           i_spd_env,        // ramp envelope limit
  input  wire logic [SPD_W-1:0]           i_accel_tol,      // allowed rise above minimum
  output logic                            o_torque_off,     // remove torque
  output logic                            o_fast_stop_ramp, // brake on fast stop ramp
  output logic                            o_brake_apply,    // brake command to link
  output logic                            o_stop_active,    // delay running
  output logic                            o_violation       // supervision tripped
);

  // ==========================================================
  // input synchronisers
  sss_sel_s pin_s1_r;  // first stage, read only by second
  sss_sel_s pin_s2_r;  // synchronised pin selection

  // pins come from outside the clock domain
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= i_sel_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ==========================================================
  // source selection
  sss_sel_s sel;  // effective selection

  // basic uses channel or pins; extended uses the configured source
  always_comb
  begin
    sel = i_sel_comm | pin_s2_r;
    if (i_cfg.extended)
    begin
      case (i_cfg.ext_src)
        SSS_SRC_COMM:  sel = i_sel_comm;
        SSS_SRC_TERM:  sel = i_sel_term;
        SSS_SRC_INPUT: sel = pin_s2_r;
        SSS_SRC_PERM:  sel = 2'b01;
        default:       sel = 2'b11;
      endcase
    end
  end

  // ==========================================================
  // speed magnitude and supervision
  logic [SPD_W-1:0] spd_abs;    // speed without sign
  logic [SPD_W-1:0] spd_min_r;  // lowest magnitude seen while braking
  logic [SPD_W:0]   accel_lim;  // minimum plus tolerance, one bit wider
  logic             low_speed;  // below shutdown threshold
  logic             viol;       // supervision tripped this cycle
  logic             ext_mode;   // extended and not external stop
  sss_state_e       state_r;
  sss_state_e       state_nxt;
  logic [SSS_DELAY_MAX_W-1:0] cnt_r;  // elapsed delay cycles
  logic             delay_done;

  // magnitude ignores direction
  assign spd_abs   = i_speed[SPD_W-1] ? SPD_W'(-i_speed) : SPD_W'(i_speed);
  assign low_speed = spd_abs < i_spd_shutdown;
  assign accel_lim = {1'b0, spd_min_r} + {1'b0, i_accel_tol};
  assign ext_mode  = i_cfg.extended && (i_cfg.mon_mode != SSS_MON_EXT);

  // one of two checks; the external option disables both
  always_comb
  begin
    viol = 1'b0;
    if (ext_mode && state_r == SSS_ST_STOP)
    begin
      case (i_cfg.mon_mode)
        SSS_MON_RAMP:  viol = spd_abs > i_spd_env;
        SSS_MON_ACCEL: viol = {1'b0, spd_abs} > accel_lim;
        default:       viol = 1'b0;
      endcase
    end
  end

  // track minimum magnitude; a rise past it plus tolerance means wrong acceleration
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
      spd_min_r <= '1;
    else if (state_r != SSS_ST_STOP)
      spd_min_r <= '1;
    else if (spd_abs < spd_min_r)
      spd_min_r <= spd_abs;
  end

  // ==========================================================
  // delay timer, started at the recognised selection
  assign delay_done = (cnt_r >= i_delay_cycles);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
      cnt_r <= SSS_DELAY_RST;
    else if (state_r == SSS_ST_RUN)
      cnt_r <= SSS_DELAY_RST;
    else if (!delay_done)
      cnt_r <= cnt_r + SSS_DELAY_MAX_W'(1);
  end

  // ==========================================================
  // sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SSS_ST_RUN:
      begin
        if (sel.torque_off)
          state_nxt = SSS_ST_TOFF;
        else if (sel.stop_one)
        begin
          // extended variant, except the external option, skips the delay for an idle motor
          if (i_cfg.extended && !i_motor_on && i_cfg.mon_mode != SSS_MON_EXT)
            state_nxt = SSS_ST_TOFF;
          else
            state_nxt = SSS_ST_STOP;
        end
      end
      SSS_ST_STOP:
      begin
        if (sel.torque_off)
          state_nxt = SSS_ST_TOFF;
        else if (!sel.stop_one)
          state_nxt = SSS_ST_RUN;
        else if (viol)
          state_nxt = SSS_ST_TOFF;
        else if (ext_mode && low_speed)
          state_nxt = SSS_ST_TOFF;
        else if (delay_done)
          state_nxt = SSS_ST_TOFF;
      end
      SSS_ST_TOFF:
      begin
        // held until every selection is withdrawn
        if (!sel.torque_off && !sel.stop_one)
          state_nxt = SSS_ST_RUN;
      end
      default: state_nxt = SSS_ST_TOFF;  // unknown code fails safe
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
      state_r <= SSS_ST_RUN;
    else
      state_r <= state_nxt;
  end

  // ==========================================================
  // outputs, registered
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      o_torque_off     <= 1'b0;
      o_fast_stop_ramp <= 1'b0;
      o_brake_apply    <= 1'b0;
      o_stop_active    <= 1'b0;
      o_violation      <= 1'b0;
    end
    else
    begin
      o_torque_off  <= (state_nxt == SSS_ST_TOFF);
      // brake command leaves with torque_off, same cycle, toward the link
      o_brake_apply <= i_cfg.brake_ctl_en && (state_nxt == SSS_ST_TOFF);
      o_stop_active <= (state_nxt == SSS_ST_STOP);
      // external option leaves braking to the outside controller
      o_fast_stop_ramp <= (state_nxt == SSS_ST_STOP) && i_motor_on
        && !(i_cfg.extended && i_cfg.mon_mode == SSS_MON_EXT);
      // a trip in the withdrawal cycle still shows for one cycle: set wins
      if (viol)
        o_violation <= 1'b1;
      else if (state_nxt == SSS_ST_RUN)
        o_violation <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  a_toff_follows_sel: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    sel.torque_off |=> o_torque_off)
    else $error("torque_off not taken");
  a_brake_with_toff: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_brake_apply |-> o_torque_off)
    else $error("brake applied without torque_off");
  a_brake_cfg_toff: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_cfg.brake_ctl_en && o_torque_off && $stable(i_cfg)) |-> o_brake_apply)
    else $error("brake not applied");
  a_viol_trips: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (viol && sel.stop_one) |=> o_torque_off && o_violation)
    else $error("violation did not trip");
  a_low_speed_trips: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state_r == SSS_ST_STOP && ext_mode && low_speed && sel.stop_one) |=> o_torque_off)
    else $error("low speed did not trip");
  a_delay_trips: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state_r == SSS_ST_STOP && delay_done && sel.stop_one) |=> o_torque_off)
    else $error("delay end did not trip");
  a_ext_no_ramp: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_cfg.extended && i_cfg.mon_mode == SSS_MON_EXT) |-> !viol)
    else $error("supervision active in external option");
  a_ramp_needs_stop: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_fast_stop_ramp |-> o_stop_active && !o_torque_off)
    else $error("ramp outside stop_one");
  a_toff_holds: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (o_torque_off && (sel.torque_off || sel.stop_one)) |=> o_torque_off)
    else $error("torque_off dropped while selected");

endmodule

// file: sss_ctrl_model.sv
// model of the fail-safe controller that raises the stop selections
`timescale 1ns/1ps

module sss_ctrl_model
  import sss_pkg::*;
(
  input  wire sss_src_e i_route,     // channel the controller uses
  input  wire sss_sel_s i_req,       // selection wanted by the controller
  output sss_sel_s      o_sel_comm,  // safety channel selection
  output sss_sel_s      o_sel_term,  // terminal module selection
  output sss_sel_s      o_sel_pin    // failsafe_input pin levels
);
  // ==========================================================
  // routing
  // only the chosen channel carries the request; idle channels sit
  // deselected, so a wrong source pick in the block cannot pass
  always_comb
  begin
    o_sel_comm = '0;
    o_sel_term = '0;
    o_sel_pin  = '0;
    case (i_route)
      SSS_SRC_COMM:  o_sel_comm = i_req;
      SSS_SRC_TERM:  o_sel_term = i_req;
      SSS_SRC_INPUT: o_sel_pin  = i_req;
      default:       ;                    // permanent selection needs no request
    endcase
  end
endmodule

// file: sss_pkg.sv
// package of constants and types for the safe stop sequencer
package sss_pkg;

  // ==========================================================
  // timing
  localparam int unsigned SSS_CLK_MHZ        = 125;        // system clock rate
  localparam int unsigned SSS_DELAY_MAX_W    = 32;         // width of delay counts
  localparam logic [31:0] SSS_DELAY_RST      = 32'h0000_0000; // counter value after reset

  // ==========================================================
  // selection sources
  typedef enum logic [1:0]
  {
    SSS_SRC_COMM  = 2'b00,  // safety communication channel
    SSS_SRC_TERM  = 2'b01,  // fail-safe terminal module
    SSS_SRC_INPUT = 2'b10,  // onboard failsafe_input
    SSS_SRC_PERM  = 2'b11   // permanently selected
  } sss_src_e;

  // extended supervision mode
  typedef enum logic [1:0]
  {
    SSS_MON_RAMP  = 2'b00,  // brake_ramp_check envelope
    SSS_MON_ACCEL = 2'b01,  // accel_check
    SSS_MON_EXT   = 2'b10   // stop_one_external, no supervision
  } sss_mon_e;

  // sequencer states
  typedef enum logic [1:0]
  {
    SSS_ST_RUN   = 2'b00,   // no function active
    SSS_ST_STOP  = 2'b01,   // stop_one delay running
    SSS_ST_TOFF  = 2'b10    // torque_off active
  } sss_state_e;

  // configuration carried as one bundle
  typedef struct packed
  {
    logic       extended;      // 1 = extended stop_one variant
    sss_mon_e   mon_mode;      // supervision choice
    logic       brake_ctl_en;  // brake_control configured
    sss_src_e   ext_src;       // selection source for extended functions
  } sss_cfg_s;

  // selection request bundle, one per source
  typedef struct packed
  {
    logic torque_off;
    logic stop_one;
  } sss_sel_s;

endpackage

// file: sss_sequencer.sv
// holds no logic: the whole safe stop sequencer is built in sss_core.sv

// file: testbench.sv
// self-checking testbench for the safe stop sequencer core
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module testbench;
  import sss_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  localparam int D = 20;             // short stop_one delay keeps runs brief
  localparam sss_sel_s STOP = 2'b01; // stop_one request only
  logic                       clk;
  logic                       rst_n;
  sss_cfg_s                   cfg;
  logic [SSS_DELAY_MAX_W-1:0] dly;
  sss_src_e                   route;
  sss_sel_s                   req;
  sss_sel_s                   sel_comm;
  sss_sel_s                   sel_term;
  sss_sel_s                   sel_pin;
  logic                       motor_on;
  logic signed [15:0]         speed;
  logic [15:0]                spd_shut;
  logic [15:0]                spd_env;
  logic [15:0]                acc_tol;
  logic                       toff;
  logic                       ramp;
  logic                       brake;
  logic                       stop_act;
  logic                       viol;
  int                         fail_count;
  int                         n_checks;
  int                         n;

  sss_ctrl_model sss_ctrl_model_i (.i_route(route), .i_req(req), .o_sel_comm(sel_comm),
    .o_sel_term(sel_term), .o_sel_pin(sel_pin));

  sss_core sss_core_i (.i_clk_sys(clk), .i_reset_n(rst_n), .i_cfg(cfg),
    .i_delay_cycles(dly), .i_sel_comm(sel_comm), .i_sel_term(sel_term),
    .i_sel_pin(sel_pin), .i_motor_on(motor_on), .i_speed(speed),
    .i_spd_shutdown(spd_shut), .i_spd_env(spd_env), .i_accel_tol(acc_tol),
    .o_torque_off(toff), .o_fast_stop_ramp(ramp), .o_brake_apply(brake),
    .o_stop_active(stop_act), .o_violation(viol));

  // ==========================================================
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // whole sequence needs about 250 cycles; give generous margin
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end

  // ==========================================================
  // shared tasks: drive on rising edges, sample on falling edges
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic go(sss_sel_s s);
    @(posedge clk);
    req <= s;
  endtask

  task automatic ticks(int k);
    repeat (k) @(negedge clk);
  endtask

  // bounded wait; count of falling edges until torque is removed
  task automatic wait_toff(output int c);
    c = 0;
    while (toff !== 1'b1 && c < 400)
    begin
      @(negedge clk);
      c++;
    end
  endtask

  task automatic setup(logic ext, sss_mon_e mon, logic brk, sss_src_e src, logic mot,
                       logic signed [15:0] spd);
    @(posedge clk);
    cfg <= '{extended: ext, mon_mode: mon, brake_ctl_en: brk, ext_src: src};
    route <= src;
    motor_on <= mot;
    speed <= spd;
  endtask

  // withdraw everything and see the block return to run
  task automatic idle();
    int k;
    k = 0;
    go('0);
    while ((toff !== 1'b0 || stop_act !== 1'b0) && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    ticks(2);
    `CHK("torque_off_release", 1'b0, toff)
    `CHK("violation_clear", 1'b0, viol)
    @(posedge clk);
    dly <= D;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_torque_off();
    setup(1'b0, SSS_MON_RAMP, 1'b1, SSS_SRC_COMM, 1'b1, 16'sd100);
    go(2'b10);
    wait_toff(n);
    `CHK("torque_off_latency", 2, n)
    `CHK("brake_with_toff", 1'b1, brake)
    ticks(30);
    `CHK("torque_off_held", 1'b1, toff)
    idle();
  endtask

  // basic variant; pin route adds two synchroniser cycles
  task automatic t_basic(logic mot, sss_src_e src, logic brk);
    int lo;
    lo = (src == SSS_SRC_INPUT) ? D + 2 : D;
    setup(1'b0, SSS_MON_RAMP, brk, src, mot, 16'sd400);
    go(STOP);
    ticks(5);
    `CHK("stop_active", 1'b1, stop_act)
    `CHK("fast_ramp", mot, ramp)
    `CHK("no_early_toff", 1'b0, toff)
    wait_toff(n);
    `CHK("toff_at_delay", 1'b1, (n + 5 >= lo && n + 5 <= lo + 4))
    `CHK("brake_follow", brk, brake)
    `CHK("stop_done", 1'b0, stop_act)
    idle();
  endtask

  // extended variant, motor off, each selection source
  task automatic t_ext_src(sss_src_e src);
    setup(1'b1, SSS_MON_RAMP, 1'b1, src, 1'b0, 16'sd0);
    go(STOP);
    wait_toff(n);
    `CHK("ext_off_toff", 1'b1, (n <= 4))
    `CHK("ext_brake", 1'b1, brake)
    if (src == SSS_SRC_PERM)
      setup(1'b1, SSS_MON_RAMP, 1'b1, SSS_SRC_COMM, 1'b0, 16'sd0);
    idle();
  endtask

  // negative speed: a sign-blind compare would miss the low speed
  task automatic t_ext_low();
    setup(1'b1, SSS_MON_RAMP, 1'b0, SSS_SRC_COMM, 1'b1, -16'sd768);
    dly <= 32'h0000_00c8;
    go(STOP);
    ticks(5);
    `CHK("ext_ramp", 1'b1, ramp)
    `CHK("ext_no_toff", 1'b0, toff)
    `CHK("ext_no_viol", 1'b0, viol)
    @(posedge clk);
    speed <= -16'sd40;
    wait_toff(n);
    `CHK("low_speed_toff", 1'b1, (n <= 3))
    idle();
  endtask

  // ramp mode trips above the envelope, accel mode on a rise past tolerance
  task automatic t_ext_viol(sss_mon_e mon);
    setup(1'b1, mon, 1'b0, SSS_SRC_COMM, 1'b1, 16'sd300);
    dly <= 32'h0000_00c8;
    go(STOP);
    ticks(5);
    `CHK("no_viol_yet", 1'b0, viol)
    @(posedge clk);
    speed <= (mon == SSS_MON_RAMP) ? 16'sd1100 : 16'sd330;
    wait_toff(n);
    `CHK("viol_toff", 1'b1, (n <= 3))
    `CHK("viol_flag", 1'b1, viol)
    idle();
  endtask

  task automatic t_ext_stop();
    setup(1'b1, SSS_MON_EXT, 1'b1, SSS_SRC_COMM, 1'b1, 16'sd1100);
    go(STOP);
    ticks(5);
    `CHK("ext_stop_no_ramp", 1'b0, ramp)
    `CHK("ext_stop_no_viol", 1'b0, viol)
    @(posedge clk);
    speed <= 16'sd60;  // outside controller slows the drive within the delay
    wait_toff(n);
    `CHK("ext_stop_delay", 1'b1, (n + 5 >= D && n + 5 <= D + 4))
    `CHK("ext_stop_viol", 1'b0, viol)
    idle();
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    cfg = '0;
    dly = D;
    route = SSS_SRC_COMM;
    req = '0;
    motor_on = 1'b0;
    speed = 16'sd0;
    spd_shut = 16'h0032;
    spd_env = 16'h03e8;
    acc_tol = 16'h0014;
    fail_count = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    ticks(2);
    `CHK("reset_toff", 1'b0, toff)
    `CHK("reset_brake", 1'b0, brake)
    t_torque_off();
    t_basic(1'b0, SSS_SRC_INPUT, 1'b0);
    t_basic(1'b1, SSS_SRC_COMM, 1'b1);
    for (int s = 0; s < 4; s++)
      t_ext_src(sss_src_e'(s));
    t_ext_low();
    t_ext_viol(SSS_MON_RAMP);
    t_ext_viol(SSS_MON_ACCEL);
    t_ext_stop();
    final_report();
  end
endmodule
